// File: hw/dbiu_cfg.svh
`ifndef DBIU_CFG_SVH
`define DBIU_CFG_SVH

// ==========================================================================
// register byte offsets
// ==========================================================================
`define DBIU_CTL_OFS      12'h000
`define DBIU_ERR_STAT_OFS 12'h004
`define DBIU_ERR_CLR_OFS  12'h008
`define DBIU_OUTST_OFS    12'h00C
`define DBIU_PACE_DIS_OFS 12'h010
// region tags: address bits above the region's own index bits
`define DBIU_STAT_TAG     8'h02
`define DBIU_CLR_TAG      8'h03
`define DBIU_ROUTE_TAG    7'h02
`define DBIU_LOAD_TAG     6'h02
`define DBIU_DEC_TAG      5'h02

// ==========================================================================
// field layout
// ==========================================================================
`define DBIU_CTL_DED_BIT  0
`define DBIU_ERR_STARVE   0
`define DBIU_ERR_DBINFO   1
`define DBIU_INFO_RSV     16'hFFC0
`define DBIU_DED_BASE     5'h10
`define DBIU_DEC_VALID    7
`define DBIU_DEC_CLASS    8

// ==========================================================================
// sizes and reset values
// ==========================================================================
`define DBIU_N_LINES      25
`define DBIU_N_GP         16
`define DBIU_N_DED        8
`define DBIU_N_DB         64
`define DBIU_PACE_RST     16'h0000

`endif

// File: hw/dbiu_pkg.sv
package dbiu_pkg;
  typedef logic [15:0] dbiu_info_t;
  typedef logic [11:0] dbiu_addr_t;
  typedef logic [31:0] dbiu_word_t;
  typedef enum logic [1:0] {
    DBIU_CLS_SVC  = 2'h0,
    DBIU_CLS_ERR  = 2'h1,
    DBIU_CLS_CRIT = 2'h3
  } dbiu_class_t;
endpackage

// File: hw/dbiu_top.sv
// Overview of operation
// R1: twenty-five interrupt outputs in three groups
// R2: dedicated doorbell lines are never paced
// R3: each condition is servicing, error or critical; dec_word tags every source DBIU_CLS_SVC
// R4: interrupts come only from link doorbells
// R5: memory writes always request a response
// R6: hold interrupts until writes are acknowledged
// R7: release only when issued equals answered
// R8: any port doorbell reaches any core
// R9: sender uses doorbell packets, no sideband
// R10: sender encodes the status bit in info
// R11: info selects register and bit, sets it
// R12: four sixteen-bit doorbell status registers
// R13: each bit routed to one line
// R14: control bit picks general or dedicated lines
// R15: reserved info bits give error response
// R16: device paces direct servicing interrupts
// R17: load write reloads down-counter, holds at zero
// R18: one pulse after zero until next load
// R19: status writable for test, clear registers
// R20: decode register names source per line
// R21: doorbell bits stay set until cleared
`timescale 1ns/1ps
`include "dbiu_cfg.svh"
`default_nettype none

module dbiu_top #(
  parameter int CNT_W = 16,
  parameter int OST_W = 8
) (
  // clock, reset, enable
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               ce,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire dbiu_pkg::dbiu_addr_t paddr,
  input  wire dbiu_pkg::dbiu_word_t pwdata,
  output var  dbiu_pkg::dbiu_word_t prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  // inbound doorbells from the link layer
  input  wire logic               db_valid,
  input  wire dbiu_pkg::dbiu_info_t db_info,
  output var  logic               db_resp_valid,
  output var  logic               db_resp_err,
  // internal dma bus write tracking
  input  wire logic               dma_wr_issue,
  input  wire logic               dma_wr_resp,
  output var  logic               dma_wr_cmd_resp,
  // packet dma starvation event
  input  wire logic               packet_dma_starve,
  // interrupt outputs
  output var  logic [23:0]        int_dest_line,
  output var  logic               packet_dma_starve_irq
);
  import dbiu_pkg::*;

  // ========================================================================
  // state
  // ========================================================================
  logic [63:0]       stat_q;
  logic [1:0]        err_q;
  logic              ded_q;
  logic [15:0]       dis_q;
  logic [31:0]       route_q [8];
  logic [CNT_W-1:0]  cnt_q [16];
  logic [15:0]       armed_q;
  logic [OST_W-1:0]  iss_q;
  logic [OST_W-1:0]  rsp_q;
  logic [23:0]       irq_q;
  logic              starve_q;
  logic              rdy_q;
  logic              err_rsp_q;
  logic [31:0]       rd_q;
  logic              dbv_q;
  logic              dbe_q;
  logic              wrr_q;

  // ========================================================================
  // apb decode
  // ========================================================================
  wire       acc     = ce & psel & penable;
  wire       commit  = acc & rdy_q;
  wire       wr      = commit & pwrite;
  wire [1:0] sub4    = paddr[3:2];
  wire [2:0] sub8    = paddr[4:2];
  wire [3:0] sub16   = paddr[5:2];
  wire [4:0] sub32   = paddr[6:2];
  wire sel_ctl   = paddr == `DBIU_CTL_OFS;
  wire sel_errs  = paddr == `DBIU_ERR_STAT_OFS;
  wire sel_errc  = paddr == `DBIU_ERR_CLR_OFS;
  wire sel_ost   = paddr == `DBIU_OUTST_OFS;
  wire sel_dis   = paddr == `DBIU_PACE_DIS_OFS;
  wire sel_stat  = paddr[11:4] == `DBIU_STAT_TAG && paddr[1:0] == 2'h0;
  wire sel_clr   = paddr[11:4] == `DBIU_CLR_TAG && paddr[1:0] == 2'h0;
  wire sel_route = paddr[11:5] == `DBIU_ROUTE_TAG && paddr[1:0] == 2'h0;
  wire sel_load  = paddr[11:6] == `DBIU_LOAD_TAG && paddr[1:0] == 2'h0;
  wire sel_dec   = paddr[11:7] == `DBIU_DEC_TAG && paddr[1:0] == 2'h0
                   && sub32 < 5'd24;
  wire mapped    = sel_ctl | sel_errs | sel_errc | sel_ost | sel_dis
                   | sel_stat | sel_clr | sel_route | sel_load | sel_dec;

  // ========================================================================
  // doorbell decode and status
  // ========================================================================
  wire        info_bad = |(db_info & `DBIU_INFO_RSV);
  wire        db_ok    = ce & db_valid & ~info_bad;
  wire [63:0] db_set   = db_ok ? (64'h0000_0000_0000_0001 << db_info[5:0])
                                 : 64'h0000_0000_0000_0000; // [R11] [R12]
  logic [63:0] clr_mask;
  logic [63:0] tst_mask;
  logic [63:0] tst_val;
  always_comb begin
    clr_mask = '0;
    tst_mask = '0;
    tst_val  = '0;
    if (wr && sel_clr)
      clr_mask[sub4*16 +: 16] = pwdata[15:0];  // [R19]
    if (wr && sel_stat) begin
      tst_mask[sub4*16 +: 16] = 16'hFFFF;
      tst_val[sub4*16 +: 16]  = pwdata[15:0];  // [R19]
    end
  end
  // set wins over clear and over a test write
  wire [63:0] stat_d = ((stat_q & ~clr_mask & ~tst_mask) | tst_val)
                       | db_set; // [R21]

  wire [1:0] err_set = {ce & db_valid & info_bad, ce & packet_dma_starve};
  wire [1:0] err_d   = (err_q & ~((wr && sel_errc) ? pwdata[1:0] : 2'h0)
                        & ~((wr && sel_errs) ? 2'h3 : 2'h0))
                       | ((wr && sel_errs) ? pwdata[1:0] : 2'h0)
                       | err_set;

  // ========================================================================
  // routing, write gate and line pending
  // ========================================================================
  wire gate_ok = iss_q == rsp_q; // [R6] [R7]
  logic [4:0]  dest [64];
  logic [63:0] hit  [24];
  logic [23:0] pend;
  genvar gb, gl;
  generate
    for (gb = 0; gb < 64; gb++) begin : g_bit
      wire [3:0] nib = route_q[gb/8][(gb%8)*4 +: 4];          // [R13]
      assign dest[gb] = ded_q ? (`DBIU_DED_BASE | {2'h0, nib[2:0]})
                              : {1'b0, nib};                  // [R14] [R8]
    end
    for (gl = 0; gl < 24; gl++) begin : g_line
      for (gb = 0; gb < 64; gb++) begin : g_hit
        assign hit[gl][gb] = stat_q[gb] & (dest[gb] == 5'(gl));
      end
      assign pend[gl] = gate_ok & (|hit[gl]);
    end
  endgenerate

  // lowest pending source on a line
  function automatic logic [31:0] dec_word(input logic [63:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) begin
        r[5:0] = 6'(i);
        r[`DBIU_DEC_VALID] = 1'b1;
      end
    end
    r[`DBIU_DEC_CLASS +: 2] = DBIU_CLS_SVC; // [R3]
    return r;
  endfunction

  // ========================================================================
  // read mux
  // ========================================================================
  wire [31:0] rd_d =
    sel_ctl   ? {31'h0, ded_q} :
    sel_errs  ? {30'h0, err_q} :
    sel_ost   ? {16'h0, 8'(rsp_q), 8'(iss_q)} :
    sel_dis   ? {16'h0, dis_q} :
    sel_stat  ? {16'h0, stat_q[sub4*16 +: 16]} :
    sel_route ? route_q[sub8] :
    sel_load  ? 32'(cnt_q[sub16]) :
    sel_dec   ? dec_word(hit[sub32]) : 32'h0000_0000; // [R20]

  // ========================================================================
  // apb handshake: ready in the second access cycle
  // ========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q     <= 1'b0;
      err_rsp_q <= 1'b0;
      rd_q      <= 32'h0000_0000;
    end else if (ce) begin
      rdy_q     <= psel & penable & ~rdy_q;
      err_rsp_q <= psel & penable & ~rdy_q & ~mapped;
      if (psel && penable && !rdy_q && !pwrite)
        rd_q <= rd_d;
    end
  end

  // ========================================================================
  // configuration and status registers
  // ========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      err_q  <= '0;
      ded_q  <= 1'b0;
      dis_q  <= '0;
      for (int i = 0; i < 8; i++)
        route_q[i] <= 32'h0000_0000;
    end else if (ce) begin
      stat_q <= stat_d;
      err_q  <= err_d;
      if (wr && sel_ctl)
        ded_q <= pwdata[`DBIU_CTL_DED_BIT];
      if (wr && sel_dis)
        dis_q <= pwdata[15:0];
      if (wr && sel_route)
        route_q[sub8] <= pwdata;
    end
  end

  // ========================================================================
  // outstanding write counters, doorbell answer
  // ========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      iss_q <= '0;
      rsp_q <= '0;
      dbv_q <= 1'b0;
      dbe_q <= 1'b0;
      wrr_q <= 1'b0;
    end else if (ce) begin
      iss_q <= iss_q + OST_W'(dma_wr_issue); // [R7]
      rsp_q <= rsp_q + OST_W'(dma_wr_resp);  // [R7]
      dbv_q <= db_valid;                     // [R4]
      dbe_q <= db_valid & info_bad;          // [R15]
      wrr_q <= 1'b1;                         // [R5]
    end
  end

  // ========================================================================
  // pacing counters and interrupt lines
  // ========================================================================
  generate
    for (gl = 0; gl < 16; gl++) begin : g_pace
      wire ld   = wr & sel_load & (sub16 == 4'(gl));
      wire fire = armed_q[gl] & (cnt_q[gl] == '0) & pend[gl];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q[gl]   <= CNT_W'(`DBIU_PACE_RST);
          armed_q[gl] <= 1'b1;
          irq_q[gl]   <= 1'b0;
        end else if (ce) begin
          if (ld) begin
            cnt_q[gl]   <= pwdata[CNT_W-1:0];    // [R17]
            armed_q[gl] <= 1'b1;
          end else begin
            if (cnt_q[gl] != '0)
              cnt_q[gl] <= cnt_q[gl] - 1'b1;     // [R17]
            if (fire && !dis_q[gl])
              armed_q[gl] <= 1'b0;               // [R18]
          end
          irq_q[gl] <= dis_q[gl] ? pend[gl] : fire; // [R16] [R18]
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q[23:16] <= '0;
      starve_q     <= 1'b0;
    end else if (ce) begin
      irq_q[23:16] <= pend[23:16];  // [R2]
      starve_q     <= err_q[`DBIU_ERR_STARVE];
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================
  assign prdata            = rd_q;
  assign pready            = rdy_q;
  assign pslverr           = err_rsp_q;
  assign db_resp_valid     = dbv_q;
  assign db_resp_err       = dbe_q;
  assign dma_wr_cmd_resp   = wrr_q;
  assign int_dest_line     = irq_q; // [R1]
  assign packet_dma_starve_irq = starve_q;

  // ========================================================================
  // checks
  // ========================================================================
  wire ld_any0 = wr & sel_load & (sub16 == 4'h0);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_resv_err_resp: assert property ( // [R15]
    ce && db_valid && info_bad |=> db_resp_valid && db_resp_err)
    else $error("reserved info bit gave no error response");
  a_db_bit_set: assert property ( // [R11]
    db_ok |=> stat_q[$past(db_info[5:0])])
    else $error("doorbell bit not set");
  a_sticky_bits: assert property ( // [R21]
    ce && clr_mask == '0 && tst_mask == '0
    |=> (stat_q & $past(stat_q)) == $past(stat_q))
    else $error("status bit dropped without clear");
  a_gate_hold: assert property ( // [R6]
    ce && iss_q != rsp_q |=> int_dest_line == 24'h00_0000)
    else $error("interrupt raised with writes outstanding");
  a_pace_wait: assert property ( // [R17]
    ce && cnt_q[0] != '0 && !dis_q[0] |=> !int_dest_line[0])
    else $error("paced line fired before count reached zero");
  a_pace_single: assert property ( // [R18]
    ce && int_dest_line[0] && !dis_q[0] && !ld_any0
    |=> !int_dest_line[0])
    else $error("paced line pulsed twice");
  a_ded_route: assert property ( // [R14]
    ce && !ded_q |=> int_dest_line[23:16] == 8'h00)
    else $error("dedicated line used in general mode");
  a_wr_resp_cmd: assert property ( // [R5]
    ce ##1 ce |=> dma_wr_cmd_resp)
    else $error("write issued without response request");
  a_apb_ready: assert property (
    ce && psel && penable && !pready ##1 ce |-> pready)
    else $error("apb access not answered");

  c_db_set:   cover property (db_ok ##1 stat_q != '0);
  c_pace_hit: cover property (!dis_q[0] && int_dest_line[0]);
  c_err_resp: cover property (db_resp_err);
  c_ded_hit:  cover property (ded_q && int_dest_line[23:16] != 8'h00);
endmodule

`default_nettype wire

// File: bench/dbiu_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// remote element: doorbell sender and dma write responder
module dbiu_peer (
  // clock
  input  wire logic                 pclk,
  // responder control
  input  wire logic                 stall,
  input  wire logic                 cmd_resp,
  // link side
  output var  logic                 db_valid,
  output var  dbiu_pkg::dbiu_info_t db_info,
  // dma side
  output var  logic                 dma_wr_issue,
  output var  logic                 dma_wr_resp
);
  import dbiu_pkg::*;
  int ost = 0;
  initial begin
    db_valid = 1'b0;
    db_info = 16'hA5A5;
    dma_wr_issue = 1'b0;
    dma_wr_resp = 1'b0;
  end
  // one in-band packet, info inverted once it is gone
  task automatic ring(input dbiu_info_t info);
    @(posedge pclk);
    db_valid <= 1'b1;
    db_info <= info;
    @(posedge pclk);
    db_valid <= 1'b0;
    db_info <= ~info;
  endtask
  task automatic issue();
    @(posedge pclk);
    dma_wr_issue <= 1'b1;
    @(posedge pclk);
    dma_wr_issue <= 1'b0;
  endtask
  // answers only writes that asked for a response
  always @(posedge pclk) begin
    if (dma_wr_issue)
      ost = ost + 1;
    if (ost > 0 && !stall && cmd_resp && !dma_wr_resp) begin
      dma_wr_resp <= 1'b1;
      ost = ost - 1;
    end else begin
      dma_wr_resp <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_dbiu_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dbiu_top;
  import dbiu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, stall, ce;
  logic        pready, pslverr, db_valid, db_resp_valid, db_resp_err;
  logic        dma_wr_issue, dma_wr_resp, dma_wr_cmd_resp;
  logic        packet_dma_starve, packet_dma_starve_irq;
  dbiu_addr_t  paddr;
  dbiu_word_t  pwdata, prdata;
  dbiu_info_t  db_info;
  logic [23:0] int_dest_line;
  logic [32:0] rq[$];
  logic        eq[$];
  logic [31:0] lfsr = 32'h2038_48f2;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          h;

  dbiu_top dbiu_top_i (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .db_valid(db_valid), .db_info(db_info), .db_resp_valid(db_resp_valid),
    .db_resp_err(db_resp_err), .dma_wr_issue(dma_wr_issue),
    .dma_wr_resp(dma_wr_resp), .dma_wr_cmd_resp(dma_wr_cmd_resp),
    .packet_dma_starve(packet_dma_starve), .int_dest_line(int_dest_line),
    .packet_dma_starve_irq(packet_dma_starve_irq));
  dbiu_peer dbiu_peer_i (.pclk(pclk), .stall(stall),
    .cmd_resp(dma_wr_cmd_resp), .db_valid(db_valid), .db_info(db_info),
    .dma_wr_issue(dma_wr_issue), .dma_wr_resp(dma_wr_resp));

  // ========================================================================
  // helpers
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input string nm, input logic [32:0] s,
                       input logic [32:0] e);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic apb(input logic w, input dbiu_addr_t a, input dbiu_word_t d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      $display("[ERR] pready exp 1 got %b", pready);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input dbiu_addr_t a, input dbiu_word_t d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input dbiu_addr_t a, input dbiu_word_t e, input logic r);
    rq.push_back({r, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task automatic ring(input dbiu_info_t info);
    eq.push_back(info[15:6] != 10'h000);
    dbiu_peer_i.ring(info);
  endtask
  task automatic watch(input int i, input int n, output int hits);
    hits = 0;
    repeat (n) begin
      @(negedge pclk);
      if (int_dest_line[i] === 1'b1)
        hits++;
    end
  endtask

  // ========================================================================
  // result monitor
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      check("prdata", {pslverr, prdata}, rq.pop_front());
    if (db_resp_valid === 1'b1)
      check("resp_err", db_resp_err, eq.pop_front());
  end
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end

  // ========================================================================
  // scenarios
  initial begin
    {presetn, psel, penable, pwrite, stall, packet_dma_starve} = 6'h00;
    ce = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    check("cmd_resp", dma_wr_cmd_resp, 1'b1);
    check("lines", int_dest_line, 24'h00_0000);
    rd(12'h000, 32'h0000_0000, 1'b0);
    rd(12'h018, 32'h0000_0000, 1'b1);
    wr(12'h010, 32'h0000_FFFF);
    wr(12'h048, 32'h0030_0000);
    rd(12'h048, 32'h0030_0000, 1'b0);
    ring(16'h0015);
    watch(3, 5, h);
    check("db_set", h != 0, 1'b1);
    rd(12'h024, 32'h0000_0020, 1'b0);
    rd(12'h10C, 32'h0000_0095, 1'b0);
    ring(16'h0040);
    ring(16'h0015);
    rd(12'h024, 32'h0000_0020, 1'b0);
    rd(12'h020, 32'h0000_0000, 1'b0);
    @(posedge pclk);
    stall <= 1'b1;
    dbiu_peer_i.issue();
    wr(12'h034, 32'h0000_0020);
    ring(16'h0015);
    watch(3, 10, h);
    check("gated", h, 0);
    rd(12'h00C, 32'h0000_0001, 1'b0);
    @(posedge pclk);
    stall <= 1'b0;
    watch(3, 10, h);
    check("released", h != 0, 1'b1);
    rd(12'h00C, 32'h0000_0101, 1'b0);
    // a write issued and answered while frozen must not be counted
    @(posedge pclk);
    ce <= 1'b0;
    dbiu_peer_i.issue();
    repeat (2) @(posedge pclk);
    ce <= 1'b1;
    rd(12'h00C, 32'h0000_0101, 1'b0);
    wr(12'h010, 32'h0000_0000);
    wr(12'h000, 32'h0000_0001);
    repeat (3) @(negedge pclk);
    watch(19, 10, h);
    check("dedicated", h, 10);
    watch(3, 5, h);
    check("general_off", h, 0);
    wr(12'h000, 32'h0000_0000);
    wr(12'h08C, 32'h0000_0014);
    watch(3, 15, h);
    check("pace_early", h, 0);
    watch(3, 30, h);
    check("pace_pulse", h, 1);
    watch(3, 30, h);
    check("pace_once", h, 0);
    rd(12'h08C, 32'h0000_0000, 1'b0);
    wr(12'h080, 32'h0000_0010);
    @(posedge pclk);
    packet_dma_starve <= 1'b1;
    @(posedge pclk);
    packet_dma_starve <= 1'b0;
    repeat (3) @(negedge pclk);
    check("starve_irq", packet_dma_starve_irq, 1'b1);
    rd(12'h004, 32'h0000_0003, 1'b0);
    wr(12'h008, 32'h0000_0003);
    rd(12'h004, 32'h0000_0000, 1'b0);
    repeat (4) begin
      lfsr = nxt(lfsr);
      wr(12'h028, lfsr);
      rd(12'h028, {16'h0000, lfsr[15:0]}, 1'b0);
    end
    wr(12'h038, 32'h0000_FFFF);
    rd(12'h028, 32'h0000_0000, 1'b0);
    repeat (5) @(posedge pclk);
    check("pending", rq.size() + eq.size(), 0);
    finish_test();
  end
endmodule
`default_nettype wire
